// *** include/mb_map_pkg.sv ***
// Purpose: shared constants of the register addressing front end
// Assumes: one flat 16-bit register address space, 16-bit registers
// Notes:   addresses are the raw values carried in the request
package mb_map_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address map
  localparam logic [15:0] ADDR_AIN_BASE     = 16'h0000;  // channel 0, high word
  localparam int          AIN_CHANNELS      = 255;       // channels 0..254
  localparam logic [15:0] AIN_WORDS         = 16'h01FE;  // 2 registers per channel
  localparam logic [15:0] ADDR_CHECK        = 16'hD73C;  // 32-bit check word
  localparam logic [31:0] CHECK_WORD        = 32'h00112233;
  localparam logic [15:0] ADDR_PATH         = 16'hECEC;  // path buffer port
  localparam logic [15:0] ADDR_CONTENT      = 16'hECEE;  // content write port
  localparam logic [15:0] ADDR_PATH_LEN     = 16'hECF0;  // path length count
  localparam logic [15:0] ADDR_GO           = 16'hECF2;  // action register

  ////////////////////////////////////////////////////////////////////////////
  // reset values and sizes
  localparam logic [15:0] PATH_LEN_RESET    = 16'h0000;
  localparam int          BUF_DEPTH_DEFAULT = 64;        // words per stream buffer
  localparam int          RESP_SLOTS        = 2;         // response buffer entries

endpackage : mb_map_pkg

// *** src/resp_buf2.sv ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   head slot drives the output directly, so the data is a flop
module resp_buf2
  import mb_map_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         in_valid_in,    // push request
  input  wire logic [W-1:0] in_data_in,     // pushed word
  output logic              in_ready_out,   // room for one more
  output logic              out_valid_out,  // head holds a word
  output logic [W-1:0]      out_data_out,   // head word
  input  wire logic         out_ready_in    // drain side takes the head
);

  typedef struct packed {
    logic [W-1:0] slot0;  // head
    logic [W-1:0] slot1;  // second entry
    logic [1:0]   cnt;    // entries held
    logic         rdy;    // registered room flag
    logic         vld;    // registered head-valid flag
  } buf_state_t;

  buf_state_t cur_ff;     // registered state
  buf_state_t nxt_cur;    // next state

  logic push;             // word accepted this cycle
  logic pop;              // head consumed this cycle

  ////////////////////////////////////////////////////////////////////////////
  // next state: shift on pop, fill the first free slot on push
  always_comb begin
    nxt_cur = cur_ff;
    push    = in_valid_in && cur_ff.rdy;
    pop     = out_ready_in && (cur_ff.cnt != 2'd0);
    if (pop) begin
      nxt_cur.slot0 = cur_ff.slot1;
    end
    if (push) begin
      // slot chosen after the shift so order is kept
      if ((cur_ff.cnt == 2'd0) || (pop && (cur_ff.cnt == 2'd1))) begin
        nxt_cur.slot0 = in_data_in;
      end else begin
        nxt_cur.slot1 = in_data_in;
      end
    end
    case ({push, pop})
      2'b10:   nxt_cur.cnt = cur_ff.cnt + 2'd1;
      2'b01:   nxt_cur.cnt = cur_ff.cnt - 2'd1;
      default: nxt_cur.cnt = cur_ff.cnt;
    endcase
    // ready is registered; it may lag one cycle but never overfills
    nxt_cur.rdy = (nxt_cur.cnt < 2'd2);
    // valid kept as its own flop so the port is not a compare of the count
    nxt_cur.vld = (nxt_cur.cnt != 2'd0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign in_ready_out  = cur_ff.rdy;
  assign out_valid_out = cur_ff.vld;
  assign out_data_out  = cur_ff.slot0;

endmodule : resp_buf2

// *** src/seq_buffer.sv ***
// Purpose: forward-only word buffer behind a single register address
// Assumes: single clock, synchronous active-low reset
// Notes:   pointers only advance; a clear restarts both at zero
module seq_buffer
  import mb_map_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH_DEFAULT,
  parameter int W     = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         clr_in,       // restart transfer
  input  wire logic [15:0]  len_in,       // words allowed this transfer
  input  wire logic         wr_en_in,     // append one word
  input  wire logic [W-1:0] wr_data_in,   // appended word
  input  wire logic         rd_en_in,     // take one word
  output logic [W-1:0]      rd_data_out,  // word at read pointer, zero if none
  output logic              has_data_out  // unread words remain
);

  localparam int PW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;  // next slot to fill
    logic [PW-1:0] rd_ptr;  // next slot to read
  } seq_state_t;

  seq_state_t cur_ff;       // registered pointers
  seq_state_t nxt_cur;      // next pointers

  logic [W-1:0] mem [0:DEPTH-1];  // word storage
  logic         wr_ok;            // write lands inside length and depth
  logic         rd_ok;            // read has a word behind it

  ////////////////////////////////////////////////////////////////////////////
  // pointer logic
  always_comb begin
    nxt_cur = cur_ff;
    wr_ok   = wr_en_in && (cur_ff.wr_ptr < PW'(DEPTH))
              && (32'(cur_ff.wr_ptr) < 32'(len_in));
    rd_ok   = rd_en_in && (cur_ff.rd_ptr < cur_ff.wr_ptr);
    if (clr_in) begin
      nxt_cur = '0;
    end else begin
      if (wr_ok) begin
        nxt_cur.wr_ptr = cur_ff.wr_ptr + PW'(1);
      end
      if (rd_ok) begin
        nxt_cur.rd_ptr = cur_ff.rd_ptr + PW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; storage needs no reset, unread slots are masked
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_ok && !clr_in) begin
      mem[cur_ff.wr_ptr[PW-2:0]] <= wr_data_in;
    end
  end

  assign has_data_out = (cur_ff.rd_ptr < cur_ff.wr_ptr);
  assign rd_data_out  = has_data_out ? mem[cur_ff.rd_ptr[PW-2:0]] : '0;

endmodule : seq_buffer

// *** src/mb_reg_front.sv ***
// Purpose: register map front end, decodes requests and serves words
// Assumes: requests arrive already parsed from the transport, same clock
// Notes:   read data leaves as bytes, high byte first, through a 2-slot buffer
module mb_reg_front
  import mb_map_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEFAULT
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        REQ_VALID_IN,       // request present
  input  wire logic        REQ_WRITE_IN,       // 1 write, 0 read
  input  wire logic [15:0] REQ_ADDR_IN,        // start address from packet
  input  wire logic [7:0]  REQ_COUNT_IN,       // registers in request
  output logic             REQ_READY_OUT,      // request taken when high
  input  wire logic        WDATA_VALID_IN,     // write word present
  input  wire logic [15:0] WDATA_IN,           // write word
  output logic             WDATA_READY_OUT,    // write word taken when high
  output logic             RESP_VALID_OUT,     // response byte present
  output logic [7:0]       RESP_BYTE_OUT,      // response byte
  input  wire logic        RESP_READY_IN,      // receiver takes byte
  input  wire logic        AIN_WR_EN_IN,       // new channel sample
  input  wire logic [7:0]  AIN_WR_CH_IN,       // channel number
  input  wire logic [31:0] AIN_WR_DATA_IN,     // float sample bits
  input  wire logic        CONTENT_RD_EN_IN,   // consumer takes content word
  output logic [15:0]      CONTENT_DATA_OUT,   // content word
  output logic             CONTENT_VALID_OUT,  // content word pulse
  output logic [15:0]      PATH_LEN_OUT,       // current path length count
  output logic             ACTION_GO_OUT,      // action pulse
  output logic             BUSY_OUT            // request in progress
);

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_HI, S_LO, S_WRITE} fsm_t;

  typedef struct packed {
    fsm_t        state;      // sequencer state
    logic [15:0] start;      // request start address
    logic [7:0]  count;      // registers requested
    logic [7:0]  idx;        // registers done
    logic [15:0] word;       // word being sent
    logic        req_rdy;    // request acceptance
    logic        wd_rdy;     // write word acceptance
    logic [15:0] path_len;   // path length count
    logic        go;         // action pulse
    logic        committed;  // content released to consumer
    logic [15:0] cdata;      // content word out
    logic        cvalid;     // content word pulse
    logic        busy;       // busy flag
  } front_state_t;

  front_state_t cur_ff;      // registered state
  front_state_t nxt_cur;     // next state

  logic [31:0] ain_mem [0:AIN_CHANNELS-1];  // latest channel values

  logic        buffered;     // start address is a buffer port
  logic [15:0] cur_addr;     // address of the register in hand
  logic [15:0] fetch_word;   // decoded read word
  logic        wd_take;      // write word accepted
  logic        rb_valid;     // byte pushed to response buffer
  logic [7:0]  rb_byte;      // pushed byte
  logic        rb_ready;     // response buffer has room
  logic        path_clr;     // restart both buffers
  logic        path_wr;      // append to path buffer
  logic        path_rd;      // take from path buffer
  logic [15:0] path_rdata;   // path buffer head
  logic        content_wr;   // append to content buffer
  logic        content_rd;   // consumer takes content
  logic [15:0] content_rdata;// content buffer head
  logic        content_has;  // content buffer not empty

  ////////////////////////////////////////////////////////////////////////////
  // address of the register in hand
  always_comb begin
    buffered = (cur_ff.start == ADDR_PATH) || (cur_ff.start == ADDR_CONTENT);
    if (buffered) begin
      cur_addr = cur_ff.start;
    end else begin
      cur_addr = cur_ff.start + {8'h00, cur_ff.idx};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode over the flat address space
  always_comb begin
    fetch_word = 16'h0000;
    path_rd    = 1'b0;
    if (cur_addr < AIN_WORDS) begin
      if (cur_addr[0]) begin
        fetch_word = ain_mem[cur_addr[8:1]][15:0];
      end else begin
        fetch_word = ain_mem[cur_addr[8:1]][31:16];
      end
    end else if (cur_addr == ADDR_CHECK) begin
      fetch_word = CHECK_WORD[31:16];
    end else if (cur_addr == (ADDR_CHECK + 16'h0001)) begin
      fetch_word = CHECK_WORD[15:0];
    end else if (cur_addr == ADDR_PATH) begin
      fetch_word = path_rdata;
      path_rd    = (cur_ff.state == S_FETCH);
    end else if (cur_addr == ADDR_PATH_LEN) begin
      fetch_word = cur_ff.path_len;
    end else begin
      // write-only and unmapped addresses read as zero
      fetch_word = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode and buffer strobes
  always_comb begin
    wd_take    = (cur_ff.state == S_WRITE) && cur_ff.wd_rdy && WDATA_VALID_IN;
    path_wr    = wd_take && (cur_addr == ADDR_PATH);
    content_wr = wd_take && (cur_addr == ADDR_CONTENT);
    path_clr   = wd_take && (cur_addr == ADDR_PATH_LEN);
    // content is handed out only after the action write
    content_rd = CONTENT_RD_EN_IN && cur_ff.committed && content_has;
    rb_valid   = (cur_ff.state == S_HI) || (cur_ff.state == S_LO);
    rb_byte    = (cur_ff.state == S_HI) ? cur_ff.word[15:8] : cur_ff.word[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.go     = 1'b0;
    nxt_cur.cvalid = 1'b0;
    case (cur_ff.state)
      S_IDLE: begin
        if (REQ_VALID_IN && cur_ff.req_rdy) begin
          nxt_cur.start   = REQ_ADDR_IN;
          nxt_cur.count   = REQ_COUNT_IN;
          nxt_cur.idx     = 8'h00;
          nxt_cur.req_rdy = 1'b0;
          if (REQ_COUNT_IN == 8'h00) begin
            // empty request: nothing to move, accept the next one
            nxt_cur.req_rdy = 1'b1;
          end else if (REQ_WRITE_IN) begin
            nxt_cur.state  = S_WRITE;
            nxt_cur.wd_rdy = 1'b1;
            nxt_cur.busy   = 1'b1;
          end else begin
            nxt_cur.state = S_FETCH;
            nxt_cur.busy  = 1'b1;
          end
        end
      end
      S_FETCH: begin
        nxt_cur.word  = fetch_word;
        nxt_cur.state = S_HI;
      end
      S_HI: begin
        // receiver stall holds the byte here, nothing is dropped
        if (rb_ready) begin
          nxt_cur.state = S_LO;
        end
      end
      S_LO: begin
        if (rb_ready) begin
          nxt_cur.idx = cur_ff.idx + 8'h01;
          if ((cur_ff.idx + 8'h01) == cur_ff.count) begin
            nxt_cur.state   = S_IDLE;
            nxt_cur.req_rdy = 1'b1;
            nxt_cur.busy    = 1'b0;
          end else begin
            nxt_cur.state = S_FETCH;
          end
        end
      end
      S_WRITE: begin
        if (wd_take) begin
          if (cur_addr == ADDR_PATH_LEN) begin
            nxt_cur.path_len  = WDATA_IN;
            nxt_cur.committed = 1'b0;
          end
          if ((cur_addr == ADDR_GO) && (WDATA_IN != 16'h0000)) begin
            nxt_cur.go        = 1'b1;
            nxt_cur.committed = 1'b1;
          end
          nxt_cur.idx = cur_ff.idx + 8'h01;
          if ((cur_ff.idx + 8'h01) == cur_ff.count) begin
            nxt_cur.state   = S_IDLE;
            nxt_cur.wd_rdy  = 1'b0;
            nxt_cur.req_rdy = 1'b1;
            nxt_cur.busy    = 1'b0;
          end
        end
      end
      default: begin
        nxt_cur.state   = S_IDLE;
        nxt_cur.req_rdy = 1'b1;
        nxt_cur.wd_rdy  = 1'b0;
        nxt_cur.busy    = 1'b0;
      end
    endcase
    if (content_rd) begin
      nxt_cur.cdata  = content_rdata;
      nxt_cur.cvalid = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      cur_ff          <= '0;
      cur_ff.state    <= S_IDLE;
      cur_ff.req_rdy  <= 1'b1;
      cur_ff.path_len <= PATH_LEN_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel value store, written by the acquisition side
  always_ff @(posedge CLK_IN) begin
    // out-of-range channel numbers are ignored
    if (AIN_WR_EN_IN && (AIN_WR_CH_IN < 8'(AIN_CHANNELS))) begin
      ain_mem[AIN_WR_CH_IN] <= AIN_WR_DATA_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stream buffers and response buffer
  seq_buffer #(.DEPTH(BUF_DEPTH), .W(16)) u_path_buf (
    .clk_in       (CLK_IN),
    .rst_n_in     (RESETN_IN),
    .clr_in       (path_clr),
    .len_in       (cur_ff.path_len),
    .wr_en_in     (path_wr),
    .wr_data_in   (WDATA_IN),
    .rd_en_in     (path_rd),
    .rd_data_out  (path_rdata),
    .has_data_out ()
  );

  // content has no length of its own; the depth bounds it
  seq_buffer #(.DEPTH(BUF_DEPTH), .W(16)) u_content_buf (
    .clk_in       (CLK_IN),
    .rst_n_in     (RESETN_IN),
    .clr_in       (path_clr),
    .len_in       (16'(BUF_DEPTH)),
    .wr_en_in     (content_wr),
    .wr_data_in   (WDATA_IN),
    .rd_en_in     (content_rd),
    .rd_data_out  (content_rdata),
    .has_data_out (content_has)
  );

  resp_buf2 #(.W(8)) u_resp_buf (
    .clk_in        (CLK_IN),
    .rst_n_in      (RESETN_IN),
    .in_valid_in   (rb_valid),
    .in_data_in    (rb_byte),
    .in_ready_out  (rb_ready),
    .out_valid_out (RESP_VALID_OUT),
    .out_data_out  (RESP_BYTE_OUT),
    .out_ready_in  (RESP_READY_IN)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign REQ_READY_OUT     = cur_ff.req_rdy;
  assign WDATA_READY_OUT   = cur_ff.wd_rdy;
  assign CONTENT_DATA_OUT  = cur_ff.cdata;
  assign CONTENT_VALID_OUT = cur_ff.cvalid;
  assign PATH_LEN_OUT      = cur_ff.path_len;
  assign ACTION_GO_OUT     = cur_ff.go;
  assign BUSY_OUT          = cur_ff.busy;

endmodule : mb_reg_front

// *** test/mb_reg_front_props.sv ***
// Purpose: port-level assertions for the register front end
// Assumes: one clock, sync active-low reset
// Notes:   timing figures follow the hand-over walks
module mb_reg_front_props
  import mb_map_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEFAULT
) (
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        REQ_VALID_IN,
  input wire logic        REQ_WRITE_IN,
  input wire logic [15:0] REQ_ADDR_IN,
  input wire logic [7:0]  REQ_COUNT_IN,
  input wire logic        REQ_READY_OUT,
  input wire logic        WDATA_VALID_IN,
  input wire logic        WDATA_READY_OUT,
  input wire logic        RESP_VALID_OUT,
  input wire logic [7:0]  RESP_BYTE_OUT,
  input wire logic        RESP_READY_IN,
  input wire logic        CONTENT_RD_EN_IN,
  input wire logic        CONTENT_VALID_OUT,
  input wire logic [15:0] PATH_LEN_OUT,
  input wire logic        ACTION_GO_OUT,
  input wire logic        BUSY_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // word taken on the write data side
  wire logic wtk = WDATA_VALID_IN && WDATA_READY_OUT;
  // request taken, nonzero count
  wire logic rtk = REQ_VALID_IN && REQ_READY_OUT && (REQ_COUNT_IN != 8'h00);
  ////////////////////////////////////////////////////////////////////////////
  AST_TAKE_DROPS_READY: assert property (rtk |=> !REQ_READY_OUT && BUSY_OUT)
    else $error("ready stayed high after a request was taken");
  AST_BUSY_NOT_READY: assert property (BUSY_OUT |-> !REQ_READY_OUT)
    else $error("busy while ready");
  AST_CHECK_FIRST_BYTE: assert property (rtk && !REQ_WRITE_IN && REQ_ADDR_IN == ADDR_CHECK
      && !RESP_VALID_OUT |=> !RESP_VALID_OUT [*2] ##1 (RESP_VALID_OUT && RESP_BYTE_OUT == 8'h00))
    else $error("check word first byte wrong or late");
  AST_RESP_HOLD: assert property (RESP_VALID_OUT && !RESP_READY_IN
      |=> RESP_VALID_OUT && $stable(RESP_BYTE_OUT))
    else $error("response byte lost under stall");
  AST_WDATA_IN_WRITE: assert property (WDATA_READY_OUT |-> BUSY_OUT)
    else $error("write data accepted outside a request");
  AST_CONTENT_CAUSE: assert property (CONTENT_VALID_OUT |-> $past(CONTENT_RD_EN_IN))
    else $error("content word without a request");
  AST_GO_PULSE: assert property (ACTION_GO_OUT |=> !ACTION_GO_OUT)
    else $error("action pulse longer than one cycle");
  AST_GO_CAUSE: assert property (ACTION_GO_OUT |-> $past(wtk) || $past(wtk, 2))
    else $error("action pulse without a written word");
  AST_LEN_CAUSE: assert property ($changed(PATH_LEN_OUT) |-> $past(wtk) || $past(wtk, 2))
    else $error("path length changed without a write");
  ////////////////////////////////////////////////////////////////////////////
  COV_STALL: cover property (RESP_VALID_OUT && !RESP_READY_IN);
  COV_GO: cover property (ACTION_GO_OUT);
  COV_CONTENT: cover property (CONTENT_VALID_OUT);
endmodule : mb_reg_front_props

bind mb_reg_front mb_reg_front_props #(.BUF_DEPTH(BUF_DEPTH)) props_u (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .REQ_VALID_IN(REQ_VALID_IN),
  .REQ_WRITE_IN(REQ_WRITE_IN), .REQ_ADDR_IN(REQ_ADDR_IN), .REQ_COUNT_IN(REQ_COUNT_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .WDATA_VALID_IN(WDATA_VALID_IN),
  .WDATA_READY_OUT(WDATA_READY_OUT), .RESP_VALID_OUT(RESP_VALID_OUT),
  .RESP_BYTE_OUT(RESP_BYTE_OUT), .RESP_READY_IN(RESP_READY_IN),
  .CONTENT_RD_EN_IN(CONTENT_RD_EN_IN), .CONTENT_VALID_OUT(CONTENT_VALID_OUT),
  .PATH_LEN_OUT(PATH_LEN_OUT), .ACTION_GO_OUT(ACTION_GO_OUT), .BUSY_OUT(BUSY_OUT));

// *** test/resp_sink_model.sv ***
// Purpose: client side that takes response bytes
// Assumes: bytes taken on valid and ready at a rising edge
// Notes:   stall mode opens ready one cycle in four only
module resp_sink_model (
  input  wire logic       clk_in,
  input  wire logic       stall_in,    // slow receiver
  input  wire logic       valid_in,    // byte offered
  input  wire logic [7:0] byte_in,     // offered byte
  output logic            ready_out    // byte taken when high
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];                  // bytes in arrival order
  logic [1:0] phase_ff = 2'h0;         // stall pattern counter
  initial ready_out = 1'b0;
  always @(posedge clk_in) begin
    if (valid_in === 1'b1 && ready_out) got.push_back(byte_in);
    phase_ff <= phase_ff + 2'h1;
    ready_out <= #1 !stall_in || (phase_ff == 2'h3);
  end
endmodule : resp_sink_model

// *** test/mb_reg_front_tb.sv ***
// Purpose: self-checking bench for the register front end
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   channel memory is filled before it is read back
module mb_reg_front_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mb_map_pkg::*;
  logic CLK_IN = 0, RESETN_IN = 0, REQ_VALID_IN = 0, REQ_WRITE_IN = 0, WDATA_VALID_IN = 0;
  logic [15:0] REQ_ADDR_IN = 16'h0000, WDATA_IN = 16'h0000, CONTENT_DATA_OUT, PATH_LEN_OUT;
  logic [7:0] REQ_COUNT_IN = 8'h00, AIN_WR_CH_IN = 8'h00, RESP_BYTE_OUT;
  logic [31:0] AIN_WR_DATA_IN = 32'h0;
  logic AIN_WR_EN_IN = 0, CONTENT_RD_EN_IN = 0, RESP_READY_IN, stall = 0;
  logic REQ_READY_OUT, WDATA_READY_OUT, RESP_VALID_OUT, CONTENT_VALID_OUT;
  logic ACTION_GO_OUT, BUSY_OUT;
  int num_errors = 0, comparisons = 0, go_count = 0;
  mb_reg_front #(.BUF_DEPTH(4)) dut_u (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .REQ_VALID_IN(REQ_VALID_IN), .REQ_WRITE_IN(REQ_WRITE_IN), .REQ_ADDR_IN(REQ_ADDR_IN),
    .REQ_COUNT_IN(REQ_COUNT_IN), .REQ_READY_OUT(REQ_READY_OUT),
    .WDATA_VALID_IN(WDATA_VALID_IN), .WDATA_IN(WDATA_IN), .WDATA_READY_OUT(WDATA_READY_OUT),
    .RESP_VALID_OUT(RESP_VALID_OUT), .RESP_BYTE_OUT(RESP_BYTE_OUT),
    .RESP_READY_IN(RESP_READY_IN), .AIN_WR_EN_IN(AIN_WR_EN_IN), .AIN_WR_CH_IN(AIN_WR_CH_IN),
    .AIN_WR_DATA_IN(AIN_WR_DATA_IN), .CONTENT_RD_EN_IN(CONTENT_RD_EN_IN),
    .CONTENT_DATA_OUT(CONTENT_DATA_OUT), .CONTENT_VALID_OUT(CONTENT_VALID_OUT),
    .PATH_LEN_OUT(PATH_LEN_OUT), .ACTION_GO_OUT(ACTION_GO_OUT), .BUSY_OUT(BUSY_OUT));
  resp_sink_model sink_u (.clk_in(CLK_IN), .stall_in(stall), .valid_in(RESP_VALID_OUT),
    .byte_in(RESP_BYTE_OUT), .ready_out(RESP_READY_IN));
  always #5 CLK_IN = ~CLK_IN;
  // counts one-cycle action pulses
  always @(posedge CLK_IN) if (ACTION_GO_OUT === 1'b1) go_count++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic ran_out(input int i);
    if (i >= 400) begin
      num_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask : ran_out
  // holds the request until an edge samples ready high
  task automatic give_req(input logic w, input logic [15:0] a, input logic [7:0] n);
    int i;
    REQ_VALID_IN = 1'b1;
    REQ_WRITE_IN = w;
    REQ_ADDR_IN = a;
    REQ_COUNT_IN = n;
    i = 0;
    do begin @(posedge CLK_IN); i++; end while (REQ_READY_OUT !== 1'b1 && i < 400);
    ran_out(i);
    #1 REQ_VALID_IN = 1'b0;
  endtask : give_req
  task automatic wait_idle;
    int i;
    i = 0;
    do begin @(posedge CLK_IN); i++; end while (REQ_READY_OUT !== 1'b1 && i < 400);
    ran_out(i);
    #1;
  endtask : wait_idle
  task automatic wr(input logic [15:0] a, input logic [15:0] w[$]);
    int i;
    give_req(1'b1, a, 8'(w.size()));
    foreach (w[k]) begin
      WDATA_VALID_IN = 1'b1;
      WDATA_IN = w[k];
      i = 0;
      do begin @(posedge CLK_IN); i++; end while (WDATA_READY_OUT !== 1'b1 && i < 400);
      ran_out(i);
      #1;
    end
    WDATA_VALID_IN = 1'b0;
    wait_idle();
  endtask : wr
  // read with the holding-register function, raw address
  task automatic rd(input logic [15:0] a, input logic [15:0] w[$]);
    int i;
    sink_u.got.delete();
    give_req(1'b0, a, 8'(w.size()));
    i = 0;
    while (sink_u.got.size() < 2 * w.size() && i < 400) begin @(posedge CLK_IN); i++; end
    ran_out(i);
    foreach (w[k]) begin
      check(sink_u.got[2*k], w[k][15:8], "high byte");
      check(sink_u.got[2*k+1], w[k][7:0], "low byte");
    end
    wait_idle();
  endtask : rd
  function automatic logic [31:0] ain_val(input logic [7:0] c);
    return {c, 8'hA5, ~c, 8'h5A};
  endfunction : ain_val
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ain;
    for (int c = 0; c < AIN_CHANNELS; c++) begin
      AIN_WR_EN_IN = 1'b1;
      AIN_WR_CH_IN = 8'(c);
      AIN_WR_DATA_IN = ain_val(8'(c));
      @(posedge CLK_IN); #1;
    end
    AIN_WR_EN_IN = 1'b0;
    rd(ADDR_AIN_BASE, {ain_val(8'h00) >> 16, ain_val(8'h00) & 32'hFFFF,
      ain_val(8'h01) >> 16, ain_val(8'h01) & 32'hFFFF});
    stall = 1'b1;
    rd(16'd508, {ain_val(8'hFE) >> 16, ain_val(8'hFE) & 32'hFFFF});
    stall = 1'b0;
    $display("test ain done");
  endtask : t_ain
  task automatic t_check;
    stall = 1'b1;
    rd(ADDR_CHECK, {16'h0011, 16'h2233});
    stall = 1'b0;
    rd(ADDR_CHECK + 16'h0001, {16'h2233});
    rd(16'h1234, {16'h0000});
    give_req(1'b0, ADDR_CHECK, 8'h00);
    check(REQ_READY_OUT, 32'h1, "empty request ready");
    check(BUSY_OUT, 32'h0, "empty request busy");
    wait_idle();
    $display("test check done");
  endtask : t_check
  task automatic t_path;
    wr(ADDR_PATH_LEN, {16'h0003});
    check(PATH_LEN_OUT, 32'h3, "path length");
    wr(ADDR_PATH, {16'hA1A1, 16'hB2B2, 16'hC3C3, 16'hD4D4});
    rd(ADDR_PATH, {16'hA1A1, 16'hB2B2, 16'hC3C3, 16'h0000});
    rd(ADDR_PATH_LEN, {16'h0003});
    wr(ADDR_PATH_LEN, {16'h0002});
    wr(ADDR_PATH, {16'hE5E5, 16'hF6F6});
    rd(ADDR_PATH, {16'hE5E5, 16'hF6F6});
    $display("test path done");
  endtask : t_path
  task automatic t_content;
    int g0;
    wr(ADDR_CONTENT, {16'h1111, 16'h2222, 16'h3333});
    check(PATH_LEN_OUT, 32'h2, "neighbour length");
    rd(ADDR_CONTENT, {16'h0000});
    CONTENT_RD_EN_IN = 1'b1;
    @(posedge CLK_IN); #1 CONTENT_RD_EN_IN = 1'b0;
    check(CONTENT_VALID_OUT, 32'h0, "content before go");
    @(posedge CLK_IN); #1;
    g0 = go_count;
    wr(ADDR_GO, {16'h0001});
    check(go_count, g0 + 1, "action pulse");
    for (int k = 0; k < 2; k++) begin
      CONTENT_RD_EN_IN = 1'b1;
      @(posedge CLK_IN); #1 CONTENT_RD_EN_IN = 1'b0;
      check(CONTENT_VALID_OUT, 32'h1, "content valid");
      check(CONTENT_DATA_OUT, k ? 32'h2222 : 32'h1111, "content word");
      @(posedge CLK_IN); #1;
      check(CONTENT_VALID_OUT, 32'h0, "content pulse length");
    end
    $display("test content done");
  endtask : t_content
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge CLK_IN);
    #1 RESETN_IN = 1'b1;
    check(REQ_READY_OUT, 32'h1, "ready after reset");
    check(PATH_LEN_OUT, PATH_LEN_RESET, "length after reset");
    t_ain();
    t_check();
    t_path();
    t_content();
    tally_and_finish();
  end
endmodule : mb_reg_front_tb
